// ==== rtl/rfis_pkg.sv ====
// constants shared by the regulator fault interrupt status block
package rfis_pkg;

   // register offsets
   localparam logic [7:0] RFIS_ADDR_RESET_CTRL = 8'h18;
   localparam logic [7:0] RFIS_ADDR_TOP_EVENT  = 8'h19;
   localparam logic [7:0] RFIS_ADDR_RESET_EVT  = 8'h1A;
   localparam logic [7:0] RFIS_ADDR_BUCK_EVENT = 8'h1B;
   localparam logic [7:0] RFIS_ADDR_LIN_EVENT  = 8'h1C;
   localparam logic [7:0] RFIS_ADDR_LIVE_STAT  = 8'h1D;

   // top_event_flags field positions
   localparam int RFIS_TOP_PV_LOSS  = 7;
   localparam int RFIS_TOP_LIN_SUM  = 6;
   localparam int RFIS_TOP_BUCK_SUM = 5;
   localparam int RFIS_TOP_SYNC_CLK = 4;
   localparam int RFIS_TOP_TSD      = 3;
   localparam int RFIS_TOP_TWARN    = 2;
   localparam int RFIS_TOP_OVP      = 1;
   localparam int RFIS_TOP_MEAS     = 0;

   // reset_event_flag and reset control positions
   localparam int RFIS_RST_EVT_BIT  = 0;
   localparam int RFIS_SWRST_BIT    = 0;

   // per-regulator field layout inside buck / linear event registers
   localparam int RFIS_GRP_PG       = 2;
   localparam int RFIS_GRP_SC       = 1;
   localparam int RFIS_GRP_ILIM     = 0;
   localparam int RFIS_GRP_STRIDE   = 4;

   // live status register positions
   localparam int RFIS_STAT_PV      = 7;
   localparam int RFIS_STAT_CLK_BAD = 4;
   localparam int RFIS_STAT_TSD     = 3;
   localparam int RFIS_STAT_TWARN   = 2;
   localparam int RFIS_STAT_OVP     = 1;

   // reset values and writable masks
   localparam logic [7:0] RFIS_FLAGS_RST   = 8'h00;
   localparam logic [7:0] RFIS_TOP_W1C     = 8'h9F;
   localparam logic [7:0] RFIS_GRP_W1C     = 8'h77;
   localparam logic [7:0] RFIS_RST_EVT_W1C = 8'h01;

   // synchroniser lanes for asynchronous analog / pin levels
   localparam int RFIS_SY_PV    = 0;
   localparam int RFIS_SY_CLK   = 1;
   localparam int RFIS_SY_TSD   = 2;
   localparam int RFIS_SY_TWARN = 3;
   localparam int RFIS_SY_OVP   = 4;
   localparam int RFIS_SY_UV    = 5;
   localparam int RFIS_SY_SC    = 6;
   localparam int RFIS_SY_ILIM  = 10;
   localparam int RFIS_SY_W     = 14;

   // regulators: 0 switcher_a, 1 switcher_b, 2 linear_reg_a, 3 linear_reg_b
   localparam int RFIS_NREG  = 4;
   localparam int RFIS_NGPO  = 2;
   localparam int RFIS_OUT_W = 6;

   // short-circuit qualification time
   localparam int RFIS_CLK_MHZ    = 250;
   localparam int RFIS_SC_TIME_US = 1000;
   localparam int RFIS_SC_CYCLES  = RFIS_SC_TIME_US * RFIS_CLK_MHZ;
   localparam int RFIS_SC_CNT_W   = 18;

endpackage : rfis_pkg

// ==== rtl/rfis_event_regs.sv ====
// latched event, summary and live status registers of the regulator fault logic
//
// Operation
// R1 - latch power-valid loss on active-to-inactive
// R2 - linear summary bit mirrors any linear flag
// R3 - buck summary bit mirrors any buck flag
// R4 - latch external clock appear or disappear
// R5 - thermal shutdown latches, kills regulators, outputs
// R6 - no regulator enable while shutdown flag set
// R7 - latch thermal warning on rising level
// R8 - overvoltage latches, kills regulators, outputs
// R9 - latch load-current measurement done
// R10 - latch reset event on undervoltage or soft reset
// R11 - reset event clears state, restarts, flag stays; no restart pulse if the flag is still set when the event occurs
// R12 - latch per-switcher power-valid event
// R13 - latch short after over 1 ms low
// R14 - latch per-switcher current limit activity
// R15 - live thermal and overvoltage status readable
// R16 - host writes one to acknowledge
// R17 - flags reset zero, reserved bits read zero
// R18 - linear register holds per-regulator write-one-clear flags
// R19 - soft reset request self-clears, resets interface
// R20 - zero writes ignored, set beats clear
module rfis_event_regs
   import rfis_pkg::*;
#(
   parameter int SC_CYCLES = RFIS_SC_CYCLES
) (
   // clock and reset
   input  wire logic                  clk_i,
   input  wire logic                  srst_i,
   // register port
   input  wire logic [7:0]            reg_addr_i,
   input  wire logic                  reg_wr_i,
   input  wire logic [7:0]            reg_wdata_i,
   output logic      [7:0]            reg_rdata_o,
   // asynchronous analog and pin levels
   input  wire logic                  power_valid_output_i,
   input  wire logic                  sync_clk_present_i,
   input  wire logic                  thermal_shutdown_live_i,
   input  wire logic                  thermal_warning_live_i,
   input  wire logic                  input_overvoltage_live_i,
   input  wire logic                  analog_supply_low_i,
   input  wire logic [RFIS_NREG-1:0]  short_low_i,
   input  wire logic [RFIS_NREG-1:0]  current_limit_i,
   // same-clock event pulses
   input  wire logic                  load_current_done_i,
   input  wire logic [RFIS_NREG-1:0]  power_valid_event_i,
   // enable requests and gated outputs
   input  wire logic [RFIS_NREG-1:0]  reg_en_req_i,
   input  wire logic [RFIS_NGPO-1:0]  gpo_req_i,
   output logic      [RFIS_NREG-1:0]  reg_en_o,
   output logic                       general_output_a_o,
   output logic                       general_output_b_o,
   // reset event side effects
   output logic                       serial_reset_o,
   output logic                       startup_restart_o
);

   typedef struct packed {
      logic [RFIS_SY_W-1:0]                      s1;
      logic [RFIS_SY_W-1:0]                      s2;
      logic [RFIS_SY_W-1:0]                      prev;
      logic [7:0]                                top;
      logic                                      rst_flag;
      logic                                      rst_prev;
      logic [7:0]                                buck;
      logic [7:0]                                lin;
      logic [RFIS_NREG-1:0][RFIS_SC_CNT_W-1:0]   sc_cnt;
      logic [RFIS_OUT_W-1:0]                     en;
      logic [RFIS_OUT_W-1:0]                     req_prev;
      logic                                      swrst;
      logic [7:0]                                rdata;
   } rfis_state_t;

   localparam logic [RFIS_SC_CNT_W-1:0] SC_LIMIT = RFIS_SC_CNT_W'(SC_CYCLES);

   rfis_state_t q;
   rfis_state_t d;

   logic [RFIS_SY_W-1:0]  async_in;
   logic [RFIS_SY_W-1:0]  rise;
   logic [RFIS_SY_W-1:0]  fall;
   logic [7:0]            buck_set;
   logic [7:0]            lin_set;
   logic [7:0]            top_set;
   logic [RFIS_OUT_W-1:0] req;
   logic                  wr_top;
   logic                  wr_rst;
   logic                  wr_buck;
   logic                  wr_lin;
   logic                  rst_event;
   logic                  kill;
   logic [7:0]            top_view;
   logic [7:0]            stat_view;

   // gather the asynchronous levels into one synchroniser vector
   assign async_in = {current_limit_i, short_low_i, analog_supply_low_i,
                      input_overvoltage_live_i, thermal_warning_live_i,
                      thermal_shutdown_live_i, sync_clk_present_i, power_valid_output_i};
   assign rise     = q.s2 & ~q.prev;
   assign fall     = ~q.s2 & q.prev;
   assign req      = {gpo_req_i, reg_en_req_i};

   // host write strobes per register
   assign wr_top  = reg_wr_i && (reg_addr_i == RFIS_ADDR_TOP_EVENT);
   assign wr_rst  = reg_wr_i && (reg_addr_i == RFIS_ADDR_RESET_EVT);
   assign wr_buck = reg_wr_i && (reg_addr_i == RFIS_ADDR_BUCK_EVENT);
   assign wr_lin  = reg_wr_i && (reg_addr_i == RFIS_ADDR_LIN_EVENT);

   // reset event: undervoltage edge or the self-clearing soft request
   assign rst_event = rise[RFIS_SY_UV] | q.swrst; // R10
   // faults that drop every running output at once
   assign kill = rise[RFIS_SY_TSD] | rise[RFIS_SY_OVP] | rst_event; // R5 R8 R11

   // summary bits are derived, never stored, so they clear with their source
   always_comb begin
      top_view                   = q.top;
      top_view[RFIS_TOP_LIN_SUM]  = |q.lin;  // R2
      top_view[RFIS_TOP_BUCK_SUM] = |q.buck; // R3
      stat_view                  = 8'h00;
      stat_view[RFIS_STAT_PV]     = q.s2[RFIS_SY_PV];
      stat_view[RFIS_STAT_CLK_BAD] = ~q.s2[RFIS_SY_CLK];
      stat_view[RFIS_STAT_TSD]    = q.s2[RFIS_SY_TSD];   // R15
      stat_view[RFIS_STAT_TWARN]  = q.s2[RFIS_SY_TWARN]; // R15
      stat_view[RFIS_STAT_OVP]    = q.s2[RFIS_SY_OVP];   // R15
   end

   // event sources for the top register
   always_comb begin
      top_set                    = 8'h00;
      top_set[RFIS_TOP_PV_LOSS]  = fall[RFIS_SY_PV];                      // R1
      top_set[RFIS_TOP_SYNC_CLK] = rise[RFIS_SY_CLK] | fall[RFIS_SY_CLK]; // R4
      top_set[RFIS_TOP_TSD]      = rise[RFIS_SY_TSD];                     // R5
      top_set[RFIS_TOP_TWARN]    = rise[RFIS_SY_TWARN];                   // R7
      top_set[RFIS_TOP_OVP]      = rise[RFIS_SY_OVP];                     // R8
      top_set[RFIS_TOP_MEAS]     = load_current_done_i;                   // R9
   end

   // per-regulator event sources, switchers to buck, linears to linear
   always_comb begin
      buck_set = 8'h00;
      lin_set  = 8'h00;
      for (int r = 0; r < RFIS_NREG; r++) begin
         logic [2:0] ev;
         ev                = 3'h0;
         ev[RFIS_GRP_PG]   = power_valid_event_i[r];                          // R12
         ev[RFIS_GRP_SC]   = q.s2[RFIS_SY_SC + r] && (q.sc_cnt[r] == SC_LIMIT); // R13
         ev[RFIS_GRP_ILIM] = q.s2[RFIS_SY_ILIM + r];                          // R14
         if (r < 2) begin
            buck_set[(r % 2) * RFIS_GRP_STRIDE +: 3] = ev;
         end else begin
            lin_set[(r % 2) * RFIS_GRP_STRIDE +: 3] = ev; // R18
         end
      end
   end

   // next state
   always_comb begin
      d      = q;
      d.s1   = async_in;
      d.s2   = q.s1;
      d.prev = q.s2;

      // write one clears, zero leaves alone, a same-cycle set wins
      d.top  = ((q.top & ~(wr_top ? (reg_wdata_i & RFIS_TOP_W1C) : 8'h00)) | top_set)
               & RFIS_TOP_W1C; // R16 R20 R17
      d.buck = ((q.buck & ~(wr_buck ? reg_wdata_i : 8'h00)) | buck_set)
               & RFIS_GRP_W1C; // R16 R20 R17
      d.lin  = ((q.lin & ~(wr_lin ? reg_wdata_i : 8'h00)) | lin_set)
               & RFIS_GRP_W1C; // R18 R20 R17
      d.rst_flag = (q.rst_flag & ~(wr_rst && reg_wdata_i[RFIS_RST_EVT_BIT]))
                   | rst_event; // R10 R20
      d.rst_prev = q.rst_flag; // R11

      // short-circuit timers saturate so the flag keeps re-arming while low
      for (int r = 0; r < RFIS_NREG; r++) begin
         if (!q.s2[RFIS_SY_SC + r]) begin
            d.sc_cnt[r] = '0;
         end else if (q.sc_cnt[r] != SC_LIMIT) begin
            d.sc_cnt[r] = q.sc_cnt[r] + RFIS_SC_CNT_W'(1); // R13
         end
      end

      // enables follow request, dropped on faults, re-armed only by a new request
      for (int o = 0; o < RFIS_OUT_W; o++) begin
         d.en[o] = req[o] && !kill && (q.en[o] || !q.req_prev[o]); // R5 R8
         if (o < RFIS_NREG && q.top[RFIS_TOP_TSD]) begin
            d.en[o] = 1'b0; // R6
         end
      end
      d.req_prev = req;

      // soft reset request lives one cycle, then clears itself
      d.swrst = reg_wr_i && (reg_addr_i == RFIS_ADDR_RESET_CTRL)
                && reg_wdata_i[RFIS_SWRST_BIT] && !q.swrst; // R19

      // a reset event returns every register to default except its own flag
      if (rst_event) begin
         d.top    = RFIS_FLAGS_RST; // R11
         d.buck   = RFIS_FLAGS_RST;
         d.lin    = RFIS_FLAGS_RST;
         d.sc_cnt = '0;
      end

      // registered read data; unmapped offsets read zero
      unique case (reg_addr_i)
         RFIS_ADDR_RESET_CTRL: d.rdata = {7'h00, q.swrst};
         RFIS_ADDR_TOP_EVENT:  d.rdata = top_view;
         RFIS_ADDR_RESET_EVT:  d.rdata = {7'h00, q.rst_flag};  // R17
         RFIS_ADDR_BUCK_EVENT: d.rdata = q.buck;
         RFIS_ADDR_LIN_EVENT:  d.rdata = q.lin;
         RFIS_ADDR_LIVE_STAT:  d.rdata = stat_view;
         default:              d.rdata = 8'h00;
      endcase
   end

   // one register for all state; synchronous reset
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         q <= '0; // R17
      end else begin
         q <= d;
      end
   end

   // outputs straight from flip-flops, except the restart pulse gated from two of them
   assign reg_rdata_o        = q.rdata;
   assign reg_en_o           = q.en[RFIS_NREG-1:0];
   assign general_output_a_o = q.en[RFIS_NREG];
   assign general_output_b_o = q.en[RFIS_NREG+1];
   assign serial_reset_o     = q.swrst;    // R19
   // restart pulse on the first cycle the reset flag is up; registered edge, no glitch
   assign startup_restart_o  = q.rst_flag && !q.rst_prev; // R11

   // checks beside the logic they guard
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);

   pv_loss_latch_a: assert property (fall[RFIS_SY_PV] && !rst_event |=> q.top[RFIS_TOP_PV_LOSS]) // R1
      else $error("power-valid loss not latched");
   lin_summary_a: assert property (reg_addr_i == RFIS_ADDR_TOP_EVENT
         |=> reg_rdata_o[RFIS_TOP_LIN_SUM] == $past(|q.lin)) // R2
      else $error("linear summary does not follow linear flags");
   buck_summary_a: assert property (reg_addr_i == RFIS_ADDR_TOP_EVENT
         |=> reg_rdata_o[RFIS_TOP_BUCK_SUM] == $past(|q.buck)) // R3
      else $error("buck summary does not follow buck flags");
   sync_clk_evt_a: assert property ((q.s2[RFIS_SY_CLK] != q.prev[RFIS_SY_CLK]) && !rst_event
         |=> q.top[RFIS_TOP_SYNC_CLK]) // R4
      else $error("clock change not latched");
   tsd_shutdown_a: assert property (rise[RFIS_SY_TSD] |=> q.top[RFIS_TOP_TSD] || q.rst_flag
         ##0 (reg_en_o == '0) && !general_output_a_o && !general_output_b_o) // R5
      else $error("thermal shutdown did not drop outputs");
   tsd_refuse_a: assert property (q.top[RFIS_TOP_TSD] |=> reg_en_o == '0) // R6
      else $error("regulator enabled during thermal shutdown flag");
   twarn_latch_a: assert property (rise[RFIS_SY_TWARN] && !rst_event
         |=> q.top[RFIS_TOP_TWARN]) // R7
      else $error("thermal warning not latched");
   ovp_shutdown_a: assert property (rise[RFIS_SY_OVP] |=> (reg_en_o == '0)
         && !general_output_a_o && !general_output_b_o) // R8
      else $error("overvoltage did not drop outputs");
   meas_latch_a: assert property (load_current_done_i && !rst_event
         |=> q.top[RFIS_TOP_MEAS]) // R9
      else $error("measurement done not latched");
   reset_event_a: assert property (q.swrst |=> q.rst_flag && q.buck == 8'h00
         && q.lin == 8'h00 && reg_en_o == '0 ##1 q.rst_flag) // R11
      else $error("reset event did not clear state or keep flag");
   short_timer_a: assert property (q.s2[RFIS_SY_SC] && q.sc_cnt[0] == SC_LIMIT && !rst_event
         |=> q.buck[RFIS_GRP_SC]) // R13
      else $error("short not latched after qualification time");
   short_early_a: assert property ($rose(q.sc_cnt[0] != '0) && q.buck == 8'h00
         && !power_valid_event_i[0] && !q.s2[RFIS_SY_ILIM] |=> !q.buck[RFIS_GRP_SC]) // R13
      else $error("short latched too early");
   reserved_zero_a: assert property (reg_addr_i == RFIS_ADDR_BUCK_EVENT
         |=> reg_rdata_o[7] == 1'b0 && reg_rdata_o[3] == 1'b0) // R17
      else $error("reserved bit reads non-zero");
   set_wins_a: assert property (wr_buck && reg_wdata_i[RFIS_GRP_PG] && power_valid_event_i[0]
         && !rst_event |=> q.buck[RFIS_GRP_PG]) // R20
      else $error("clear beat a same-cycle event");
   swrst_self_clear_a: assert property (q.swrst |=> !q.swrst ##0 serial_reset_o == 1'b0) // R19
      else $error("soft reset request did not self-clear");
   stat_live_a: assert property (reg_addr_i == RFIS_ADDR_LIVE_STAT
         |=> reg_rdata_o[RFIS_STAT_TSD] == $past(q.s2[RFIS_SY_TSD])) // R15
      else $error("live shutdown status wrong");

   tsd_event_c: cover property (rise[RFIS_SY_TSD] ##[1:20] wr_top);
   soft_reset_c: cover property (q.swrst ##1 q.rst_flag);
   short_c: cover property (q.sc_cnt[0] == SC_LIMIT ##1 q.buck[RFIS_GRP_SC]);

endmodule : rfis_event_regs

// ==== bench/rfis_host.sv ====
// host-side model driving the register port of the event registers
module rfis_host (
   // clock
   input  wire logic       clk_i,
   // register port towards the device
   output logic      [7:0] reg_addr_o,
   output logic            reg_wr_o,
   output logic      [7:0] reg_wdata_o,
   input  wire logic [7:0] reg_rdata_i
);
   timeunit 1ns;
   timeprecision 100ps;

   // idle port at time zero
   initial begin
      reg_addr_o  = 8'h00;
      reg_wr_o    = 1'h0;
      reg_wdata_o = 8'h00;
   end

   // one write; data lines scrambled after, so no stale value helps
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      reg_addr_o  <= a;
      reg_wr_o    <= 1'h1;
      reg_wdata_o <= d;
      @(posedge clk_i);
      reg_wr_o    <= 1'h0;
      reg_wdata_o <= ~d;
   endtask

   // read data is registered: it shows one edge after the address
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      reg_addr_o <= a;
      @(posedge clk_i);
      #1;
      d = reg_rdata_i;
   endtask
endmodule // rfis_host

// ==== bench/regulator_fault_interrupt_status_test.sv ====
// self-checking testbench of the regulator fault event registers
`define CHK(got, exp) begin \
   cmp_count++; \
   if ((got) !== (exp)) begin \
      fail_count++; \
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); \
   end \
end
module regulator_fault_interrupt_status_test import rfis_pkg::*; ;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int SC    = 20;
   localparam int LIMIT = 20000;
   logic       clk_i = 1'h0;
   logic       srst_i = 1'h1;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, bexp, lexp, w, a;
   logic       reg_wr, gpa, gpb, ser_rst, restart;
   logic       pv_out = 1'h0, clk_ok = 1'h0, tsd = 1'h0, twarn = 1'h0;
   logic       ovp = 1'h0, uv = 1'h0, ldd = 1'h0;
   logic [3:0] sc = 4'h0, ilim = 4'h0, pve = 4'h0, req = 4'h0, en, r;
   logic [1:0] general_output_a = 2'h0;
   int         fail_count = 0, cmp_count = 0, cyc = 0;

   // 250 MHz clock
   always #2 clk_i = ~clk_i;

   rfis_event_regs #(.SC_CYCLES(SC)) dut (
      .clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr), .reg_wr_i(reg_wr),
      .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata), .power_valid_output_i(pv_out),
      .sync_clk_present_i(clk_ok), .thermal_shutdown_live_i(tsd),
      .thermal_warning_live_i(twarn), .input_overvoltage_live_i(ovp),
      .analog_supply_low_i(uv), .short_low_i(sc), .current_limit_i(ilim),
      .load_current_done_i(ldd), .power_valid_event_i(pve), .reg_en_req_i(req),
      .gpo_req_i(general_output_a), .reg_en_o(en), .general_output_a_o(gpa), .general_output_b_o(gpb),
      .serial_reset_o(ser_rst), .startup_restart_o(restart));

   rfis_host host (.clk_i(clk_i), .reg_addr_o(reg_addr), .reg_wr_o(reg_wr),
      .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata));

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // read and compare under a mask
   task automatic rchk(input logic [7:0] ad, input logic [7:0] e, input logic [7:0] m = 8'hFF);
      logic [7:0] d;
      host.rd(ad, d);
      `CHK(d & m, e)
   endtask

   // power-valid pulses land in bit 2 (first unit) and bit 6 (second)
   function automatic logic [7:0] pvmap(input logic lo, input logic hi);
      return {1'h0, hi, 3'h0, lo, 2'h0};
   endfunction

   // a set in the clearing cycle wins over the clear
   function automatic logic [7:0] nxt(input logic [7:0] o, wd, s);
      return (o & ~(wd & RFIS_GRP_W1C)) | s;
   endfunction

   task automatic done(input string s);
      $display("test %s done, %0d compares", s, cmp_count);
   endtask

   task automatic results();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // thermal (k=0) or overvoltage (k=1) shutdown of all outputs
   task automatic fault(input int k);
      @(posedge clk_i);
      req <= 4'hF;
      general_output_a <= 2'h3;
      tick(3);
      #1;
      `CHK({en, gpa, gpb}, 6'h3F)
      @(posedge clk_i);
      {tsd, ovp} <= (k == 0) ? 2'h2 : 2'h1;
      tick(8);
      #1;
      `CHK({en, gpa, gpb}, 6'h00)
      rchk(RFIS_ADDR_TOP_EVENT, (k == 0) ? 8'h08 : 8'h02, 8'h0A);
      rchk(RFIS_ADDR_LIVE_STAT, (k == 0) ? 8'h08 : 8'h02, 8'h0A);
      @(posedge clk_i);
      req <= 4'h0;
      tick(2);
      req <= 4'hF;
      tick(4);
      #1;
      `CHK(en, (k == 0) ? 4'h0 : 4'hF)
      @(posedge clk_i);
      {tsd, ovp} <= 2'h0;
      req <= 4'h0;
      host.wr(RFIS_ADDR_TOP_EVENT, 8'h0A);
      rchk(RFIS_ADDR_TOP_EVENT, 8'h00);
      @(posedge clk_i);
      req <= 4'hF;
      tick(3);
      #1;
      `CHK(en, 4'hF)
      @(posedge clk_i);
      req <= 4'h0;
      general_output_a <= 2'h0;
   endtask

   // hang guard
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         fail_count++;
         results();
      end
   end

   initial begin
      void'($urandom(32'hFEFB));
      repeat (6) @(posedge clk_i);
      srst_i <= 1'h0;
      for (int i = 8'h18; i < 8'h1D; i++) rchk(8'(i), 8'h00);
      rchk(8'hFF, 8'h00);
      rchk(RFIS_ADDR_LIVE_STAT, 8'h10);
      host.wr(RFIS_ADDR_RESET_EVT, 8'hFF);
      rchk(RFIS_ADDR_RESET_EVT, 8'h00);
      done("defaults");
      @(posedge clk_i);
      ldd <= 1'h1;
      pve <= 4'h5;
      @(posedge clk_i);
      ldd <= 1'h0;
      pve <= 4'h0;
      rchk(RFIS_ADDR_TOP_EVENT, 8'h61);
      rchk(RFIS_ADDR_BUCK_EVENT, 8'h04);
      rchk(RFIS_ADDR_LIN_EVENT, 8'h04);
      host.wr(RFIS_ADDR_BUCK_EVENT, 8'h00);
      rchk(RFIS_ADDR_BUCK_EVENT, 8'h04);
      host.wr(RFIS_ADDR_BUCK_EVENT, 8'h04);
      rchk(RFIS_ADDR_TOP_EVENT, 8'h41);
      host.wr(RFIS_ADDR_LIN_EVENT, 8'h04);
      host.wr(RFIS_ADDR_TOP_EVENT, 8'hFF);
      rchk(RFIS_ADDR_TOP_EVENT, 8'h00);
      done("pulses");
      @(posedge clk_i);
      pv_out <= 1'h1;
      clk_ok <= 1'h1;
      twarn <= 1'h1;
      tick(8);
      rchk(RFIS_ADDR_LIVE_STAT, 8'h84);
      @(posedge clk_i);
      pv_out <= 1'h0;
      twarn <= 1'h0;
      ilim <= 4'h7;
      tick(3);
      ilim <= 4'h0;
      tick(8);
      rchk(RFIS_ADDR_BUCK_EVENT, 8'h11);
      rchk(RFIS_ADDR_LIN_EVENT, 8'h01);
      rchk(RFIS_ADDR_TOP_EVENT, 8'hF4);
      for (int i = 8'h19; i < 8'h1D; i++) host.wr(8'(i), 8'hFF);
      rchk(RFIS_ADDR_TOP_EVENT, 8'h00);
      @(posedge clk_i);
      sc <= 4'h3;
      tick(SC - 5);
      sc <= 4'h0;
      tick(8);
      rchk(RFIS_ADDR_BUCK_EVENT, 8'h00);
      @(posedge clk_i);
      sc <= 4'h3;
      tick(SC + 10);
      rchk(RFIS_ADDR_BUCK_EVENT, 8'h22);
      @(posedge clk_i);
      sc <= 4'h0;
      // let the synchronised level drop, else the set beats the clear
      tick(4);
      host.wr(RFIS_ADDR_BUCK_EVENT, 8'h22);
      rchk(RFIS_ADDR_BUCK_EVENT, 8'h00);
      done("levels");
      fault(0);
      fault(1);
      done("faults");
      @(posedge clk_i);
      req <= 4'hF;
      pve <= 4'h1;
      @(posedge clk_i);
      pve <= 4'h0;
      host.wr(RFIS_ADDR_RESET_CTRL, 8'h01);
      #1;
      `CHK(ser_rst, 1'h1)
      @(posedge clk_i);
      #1;
      `CHK({en, restart}, 5'h01)
      rchk(RFIS_ADDR_RESET_EVT, 8'h01);
      rchk(RFIS_ADDR_BUCK_EVENT, 8'h00);
      rchk(RFIS_ADDR_RESET_CTRL, 8'h00);
      host.wr(RFIS_ADDR_RESET_EVT, 8'hFE);
      rchk(RFIS_ADDR_RESET_EVT, 8'h01);
      host.wr(RFIS_ADDR_RESET_EVT, 8'h01);
      rchk(RFIS_ADDR_RESET_EVT, 8'h00);
      @(posedge clk_i);
      req <= 4'h0;
      uv <= 1'h1;
      tick(8);
      rchk(RFIS_ADDR_RESET_EVT, 8'h01);
      @(posedge clk_i);
      uv <= 1'h0;
      host.wr(RFIS_ADDR_RESET_EVT, 8'h01);
      done("reset events");
      bexp = 8'h00;
      lexp = 8'h00;
      for (int i = 0; i < 40; i++) begin
         r = 4'($urandom());
         w = 8'($urandom());
         a = $urandom_range(1) ? RFIS_ADDR_BUCK_EVENT : RFIS_ADDR_LIN_EVENT;
         // event pulse lands on the same edge as the clearing write
         fork
            host.wr(a, w);
            begin
               @(posedge clk_i);
               pve <= r;
               @(posedge clk_i);
               pve <= 4'h0;
            end
         join
         bexp = nxt(bexp, (a == RFIS_ADDR_BUCK_EVENT) ? w : 8'h00, pvmap(r[0], r[1]));
         lexp = nxt(lexp, (a == RFIS_ADDR_LIN_EVENT) ? w : 8'h00, pvmap(r[2], r[3]));
         rchk(RFIS_ADDR_BUCK_EVENT, bexp);
         rchk(RFIS_ADDR_LIN_EVENT, lexp);
         rchk(RFIS_ADDR_TOP_EVENT, {1'h0, |lexp, |bexp, 5'h00}, 8'h60);
      end
      done("random");
      results();
   end
endmodule // regulator_fault_interrupt_status_test
